// [core/axil_slave.sv]
// axi4-lite slave front end for the controller registers
`timescale 1ns/1ps
module axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic [31:0] reg_rdata,
  output logic             reg_wr,
  output logic [7:0]       reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb
);
  logic aw_have_q;
  logic w_have_q;

  assign reg_wr = aw_have_q && w_have_q && !s_bvalid;
  assign s_bresp = 2'h0;
  assign s_rresp = 2'h0;

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      reg_waddr <= 8'h00;
      reg_wdata <= 32'h00000000;
      reg_wstrb <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        s_awready <= 1'b0;
        reg_waddr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_q  <= 1'b1;
        s_wready  <= 1'b0;
        reg_wdata <= s_wdata;
        reg_wstrb <= s_wstrb;
      end
      if (reg_wr) begin
        s_bvalid <= 1'b1;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // read data latched at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h00000000;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= reg_rdata;
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end
endmodule

// [core/flash_cycle.sv]
// one asynchronous flash bus cycle, read or write
`timescale 1ns/1ps
module flash_cycle
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              start,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [15:0]       wdata,
  output logic                   done,
  output logic [15:0]            rdata,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [15:0]            fl_dq_o,
  output logic                   fl_dq_oe,
  input  wire logic [15:0]       fl_dq_i,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n
);
  typedef enum logic [2:0] {
    CY_IDLE  = 3'b001,
    CY_PULSE = 3'b010,
    CY_REC   = 3'b100
  } cyc_state_e;

  cyc_state_e cst_q;
  logic [7:0] cnt_q;
  logic       wr_q;

  // chip enable drops every cycle, so status is refreshed each read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cst_q    <= CY_IDLE;
      cnt_q    <= 8'h00;
      wr_q     <= 1'b0;
      done     <= 1'b0;
      rdata    <= 16'h0000;
      fl_addr  <= '0;
      fl_dq_o  <= 16'h0000;
      fl_dq_oe <= 1'b0;
      fl_ce_n  <= 1'b1;
      fl_oe_n  <= 1'b1;
      fl_we_n  <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (cst_q)
        CY_IDLE: if (start) begin
          cst_q    <= CY_PULSE;
          cnt_q    <= 8'h00;
          wr_q     <= wr;
          fl_addr  <= addr;
          fl_dq_o  <= wdata;
          fl_dq_oe <= wr;
          fl_ce_n  <= 1'b0;
          fl_oe_n  <= wr;
          fl_we_n  <= !wr;
        end
        CY_PULSE: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'((wr_q ? WR_PULSE_CYC : RD_PULSE_CYC) - 1)) begin
            cst_q   <= CY_REC;
            cnt_q   <= 8'h00;
            rdata   <= fl_dq_i;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
          end
        end
        CY_REC: begin
          // data held one edge past the strobe for hold time
          fl_dq_oe <= 1'b0;
          cnt_q    <= cnt_q + 8'h01;
          if (cnt_q == 8'(RECOVER_CYC - 1)) begin
            cst_q <= CY_IDLE;
            done  <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// [core/flash_host.sv]
// flash host: suspend, resume, query and block status sequencer
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W    = 22,
  parameter int BLK_SHIFT = $clog2(BLK1_BASE)
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [15:0]            fl_dq_o,
  output logic                   fl_dq_oe,
  input  wire logic [15:0]       fl_dq_i,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n
);
  import flash_host_pkg::*;

  // refused at elaboration, before any cycle runs
  if (ADDR_W < 16 || ADDR_W > 32 || BLK_SHIFT < 4 || BLK_SHIFT >= ADDR_W) begin : g_bad_param
    $error("flash_host: unsupported ADDR_W or BLK_SHIFT");
  end

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_STAT = 5'b00100,
    ST_POLL = 5'b01000,
    ST_READ = 5'b10000
  } seq_state_e;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic is_query(input logic [2:0] op);
    return op == OP_QREAD || op == OP_QFIELD || op == OP_BLOCK || op == OP_QID;
  endfunction

  function automatic logic [7:0] first_cmd(input logic [2:0] op);
    unique case (op)
      OP_SUSPEND: return CMD_SUSPEND;
      OP_RESUME:  return CMD_RESUME;
      OP_ARRAY:   return CMD_ARRAY;
      default:    return CMD_QUERY;
    endcase
  endfunction

  // field start and length minus one, in words
  function automatic logic [9:0] field_loc(input logic [1:0] sel);
    unique case (sel)
      2'h0:    return {2'h1, QRY_PRI_OFF};
      2'h1:    return {2'h1, QRY_EXT_OFF};
      2'h2:    return {2'h1, QRY_ALT_OFF};
      default: return {2'h0, QRY_GEOM_OFF};
    endcase
  endfunction

  function automatic logic [ADDR_W-BLK_SHIFT-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLK_SHIFT];
  endfunction

  seq_state_e          state_q;
  logic [31:0]         ctrl_q;
  logic [31:0]         addr_reg_q;
  logic [31:0]         pblk_q;
  logic [2:0]          op_q;
  logic [ADDR_W-1:0]   rd_addr_q;
  logic [1:0]          idx_q;
  logic [1:0]          last_q;
  logic [31:0]         data_q;
  logic [7:0]          lock_q;
  logic                pend_q;
  logic                ready_q;
  logic                paused_q;
  logic                qmode_q;
  logic                qry_ok_q;
  logic                err_upper_q;
  logic                err_block_q;
  logic                err_rsv_q;
  logic                cyc_start_q;
  logic                cyc_wr_q;
  logic [ADDR_W-1:0]   cyc_addr_q;
  logic [15:0]         cyc_wdata_q;
  logic                cyc_done;
  logic [15:0]         cyc_rdata;
  logic                reg_wr;
  logic [7:0]          reg_waddr;
  logic [31:0]         reg_wdata;
  logic [3:0]          reg_wstrb;
  logic [31:0]         reg_rdata;
  logic                go;
  logic [2:0]          wop;
  logic [9:0]          floc;
  logic [ADDR_W-1:0]   uaddr;

  axil_slave u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .reg_rdata (reg_rdata),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb)
  );

  flash_cycle #(.ADDR_W(ADDR_W)) u_cyc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (cyc_start_q),
    .wr       (cyc_wr_q),
    .addr     (cyc_addr_q),
    .wdata    (cyc_wdata_q),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .fl_addr  (fl_addr),
    .fl_dq_o  (fl_dq_o),
    .fl_dq_oe (fl_dq_oe),
    .fl_dq_i  (fl_dq_i),
    .fl_ce_n  (fl_ce_n),
    .fl_oe_n  (fl_oe_n),
    .fl_we_n  (fl_we_n)
  );

  // a ctrl write while busy is dropped, not queued
  assign wop   = reg_wdata[2:0];
  assign go    = reg_wr && reg_waddr == OFF_CTRL && reg_wstrb[0] && wop != OP_NONE
                 && state_q == ST_IDLE;
  assign floc  = field_loc(reg_wdata[CTRL_SEL_POS +: 2]);
  assign uaddr = addr_reg_q[ADDR_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= CTRL_RST;
      addr_reg_q <= ADDR_RST;
      pblk_q     <= PBLK_RST;
    end else if (reg_wr) begin
      if (reg_waddr == OFF_CTRL) ctrl_q <= wmerge(ctrl_q, reg_wdata, reg_wstrb);
      if (reg_waddr == OFF_ADDR) addr_reg_q <= wmerge(addr_reg_q, reg_wdata, reg_wstrb);
      if (reg_waddr == OFF_PBLK) pblk_q <= wmerge(pblk_q, reg_wdata, reg_wstrb);
    end
  end

  always_comb begin
    unique case (s_araddr)
      OFF_CTRL:   reg_rdata = ctrl_q;
      OFF_ADDR:   reg_rdata = addr_reg_q;
      OFF_PBLK:   reg_rdata = pblk_q;
      OFF_STATUS: reg_rdata = {24'h000000, err_rsv_q, err_block_q, err_upper_q, qry_ok_q,
                               qmode_q, paused_q, ready_q, state_q != ST_IDLE};
      OFF_DATA:   reg_rdata = data_q;
      OFF_LOCK:   reg_rdata = {24'h000000, lock_q};
      default:    reg_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_NONE;
      rd_addr_q   <= '0;
      idx_q       <= 2'h0;
      last_q      <= 2'h0;
      data_q      <= 32'h00000000;
      lock_q      <= 8'h00;
      pend_q      <= 1'b0;
      ready_q     <= 1'b0;
      paused_q    <= 1'b0;
      qmode_q     <= 1'b0;
      qry_ok_q    <= 1'b0;
      err_upper_q <= 1'b0;
      err_block_q <= 1'b0;
      err_rsv_q   <= 1'b0;
      cyc_start_q <= 1'b0;
      cyc_wr_q    <= 1'b0;
      cyc_addr_q  <= '0;
      cyc_wdata_q <= 16'h0000;
    end else begin
      cyc_start_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: if (go) begin
          op_q        <= wop;
          idx_q       <= 2'h0;
          data_q      <= 32'h00000000;
          err_upper_q <= 1'b0;
          err_block_q <= 1'b0;
          err_rsv_q   <= 1'b0;
          rd_addr_q   <= uaddr;
          last_q      <= reg_wdata[CTRL_LEN_POS +: 2];
          if (wop == OP_QFIELD) begin
            rd_addr_q <= ADDR_W'(floc[7:0]);
            last_q    <= floc[9:8];
          end else if (wop == OP_BLOCK) begin
            rd_addr_q <= ADDR_W'({uaddr, BLK_SHIFT'(0)}) + ADDR_W'(BLK_STAT_OFF);
            last_q    <= 2'h0;
          end else if (wop == OP_QID) begin
            rd_addr_q <= ADDR_W'(QRY_ID_OFF);
            last_q    <= 2'h2;
          end
          if (wop == OP_ARRAY && paused_q
              && blk_of(uaddr) == pblk_q[ADDR_W-BLK_SHIFT-1:0]) begin
            err_block_q <= 1'b1;
          end else if (wop == OP_QREAD && uaddr >= ADDR_W'(QRY_RSV_LO)
                       && uaddr <= ADDR_W'(QRY_RSV_HI)) begin
            err_rsv_q <= 1'b1;
          end else if (is_query(wop) && qmode_q) begin
            state_q <= ST_READ;
          end else begin
            state_q <= ST_CMD;
          end
        end
        ST_CMD: if (!pend_q) begin
          pend_q      <= 1'b1;
          cyc_start_q <= 1'b1;
          cyc_wr_q    <= 1'b1;
          cyc_addr_q  <= uaddr;
          cyc_wdata_q <= {8'h00, first_cmd(op_q)};
        end else if (cyc_done) begin
          pend_q  <= 1'b0;
          qmode_q <= is_query(op_q);
          if (op_q == OP_SUSPEND) begin
            state_q <= ST_STAT;
          end else if (op_q == OP_RESUME) begin
            paused_q <= 1'b0;
            ready_q  <= 1'b0;
            state_q  <= ST_IDLE;
          end else begin
            state_q <= ST_READ;
          end
        end
        ST_STAT: if (!pend_q) begin
          pend_q      <= 1'b1;
          cyc_start_q <= 1'b1;
          cyc_wr_q    <= 1'b1;
          cyc_addr_q  <= uaddr;
          cyc_wdata_q <= {8'h00, CMD_STATUS};
        end else if (cyc_done) begin
          pend_q  <= 1'b0;
          state_q <= ST_POLL;
        end
        ST_POLL: if (!pend_q) begin
          pend_q      <= 1'b1;
          cyc_start_q <= 1'b1;
          cyc_wr_q    <= 1'b0;
          cyc_addr_q  <= uaddr;
        end else if (cyc_done) begin
          pend_q  <= 1'b0;
          data_q  <= {16'h0000, cyc_rdata};
          ready_q <= cyc_rdata[SR_READY_BIT];
          // wait ready then take suspend state
          if (cyc_rdata[SR_READY_BIT]) begin
            paused_q <= cyc_rdata[SR_PAUSED_BIT];
            state_q  <= ST_IDLE;
          end
        end
        ST_READ: if (!pend_q) begin
          pend_q      <= 1'b1;
          cyc_start_q <= 1'b1;
          cyc_wr_q    <= 1'b0;
          cyc_addr_q  <= rd_addr_q;
        end else if (cyc_done) begin
          pend_q    <= 1'b0;
          rd_addr_q <= rd_addr_q + ADDR_W'(1);
          idx_q     <= idx_q + 2'h1;
          if (op_q == OP_ARRAY) begin
            data_q <= {16'h0000, cyc_rdata};
          end else begin
            data_q[8*idx_q +: 8] <= cyc_rdata[7:0];
            if (cyc_rdata[15:8] != 8'h00) err_upper_q <= 1'b1;
          end
          if (op_q == OP_BLOCK) begin
            lock_q <= cyc_rdata[7:0];
            if (cyc_rdata[7:2] != 6'h00) err_rsv_q <= 1'b1;
          end
          if (op_q == OP_QID && idx_q == 2'h2) begin
            qry_ok_q <= {cyc_rdata[7:0], data_q[15:0]} == QRY_STRING;
          end
          if (idx_q == last_q || op_q == OP_ARRAY) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_suspend_byte: assert property (
    cyc_start_q && state_q == ST_CMD && op_q == OP_SUSPEND |-> cyc_wdata_q[7:0] == CMD_SUSPEND
  ) else $error("suspend command byte wrong");

  chk_status_after: assert property (
    state_q == ST_CMD && op_q == OP_SUSPEND && cyc_done |=> state_q == ST_STAT ##1
    cyc_start_q && cyc_wr_q && cyc_wdata_q[7:0] == CMD_STATUS
  ) else $error("status command not issued after suspend");

  chk_strobe_toggle: assert property (
    cyc_done |-> fl_ce_n && fl_oe_n && fl_we_n
  ) else $error("enables not released between cycles");

  chk_poll_ready: assert property (
    state_q == ST_POLL && cyc_done && !cyc_rdata[SR_READY_BIT] |=> state_q == ST_POLL
  ) else $error("poll left while engine busy");

  chk_block_guard: assert property (
    cyc_start_q && !cyc_wr_q && op_q == OP_ARRAY && paused_q |->
    blk_of(cyc_addr_q) != pblk_q[ADDR_W-BLK_SHIFT-1:0]
  ) else $error("array read from suspended block");

  chk_resume_clear: assert property (
    state_q == ST_CMD && op_q == OP_RESUME && cyc_done |-> cyc_wdata_q[7:0] == CMD_RESUME
    ##1 !paused_q && state_q == ST_IDLE
  ) else $error("resume did not clear suspend state");

  chk_query_mode: assert property (
    cyc_start_q && !cyc_wr_q && state_q == ST_READ && is_query(op_q) |-> qmode_q
  ) else $error("query read outside query mode");

  cov_suspended: cover property (state_q == ST_POLL && cyc_done && cyc_rdata[7] && cyc_rdata[2]);
  cov_qry_ok: cover property (!qry_ok_q ##1 qry_ok_q);
  cov_lock: cover property (op_q == OP_BLOCK && state_q == ST_READ && cyc_done);
endmodule

// [shared/flash_host_pkg.sv]
// constants shared by the flash query and suspend host controller
// Summary of operation
// - suspend by writing B0 to any address
// - then write 70, read status anywhere
// - toggle chip or output enable per read
// - suspended: write FF, read other blocks only
// - resume by writing D0 to any address
package flash_host_pkg;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_STATUS  = 8'h70;
  localparam logic [7:0] CMD_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_RESUME  = 8'hD0;
  localparam logic [7:0] CMD_QUERY   = 8'h98;
  localparam int SR_READY_BIT  = 7;
  localparam int SR_PAUSED_BIT = 2;
  localparam int BSR_LOCKED_BIT   = 0;
  localparam int BSR_LOCKDOWN_BIT = 1;
  localparam logic [7:0] QRY_MFR_OFF   = 8'h00;
  localparam logic [7:0] QRY_RSV_LO    = 8'h04;
  localparam logic [7:0] QRY_RSV_HI    = 8'h0F;
  localparam logic [7:0] QRY_ID_OFF    = 8'h10;
  localparam logic [7:0] QRY_PRI_OFF   = 8'h13;
  localparam logic [7:0] QRY_EXT_OFF   = 8'h15;
  localparam logic [7:0] QRY_ALT_OFF   = 8'h17;
  localparam logic [7:0] QRY_SYS_OFF   = 8'h1B;
  localparam logic [7:0] QRY_GEOM_OFF  = 8'h27;
  localparam logic [7:0] BLK_STAT_OFF  = 8'h02;
  localparam logic [23:0] QRY_STRING   = 24'h595251;
  localparam int BLK1_BASE = 32'h00008000;
  // register map of the controller
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_PBLK   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_LOCK   = 8'h14;
  localparam logic [31:0] CTRL_RST  = 32'h00000000;
  localparam logic [31:0] ADDR_RST  = 32'h00000000;
  localparam logic [31:0] PBLK_RST  = 32'h00000000;
  localparam int CTRL_LEN_POS = 4;
  localparam int CTRL_SEL_POS = 8;
  localparam logic [2:0] OP_NONE    = 3'h0;
  localparam logic [2:0] OP_SUSPEND = 3'h1;
  localparam logic [2:0] OP_RESUME  = 3'h2;
  localparam logic [2:0] OP_ARRAY   = 3'h3;
  localparam logic [2:0] OP_QREAD   = 3'h4;
  localparam logic [2:0] OP_QFIELD  = 3'h5;
  localparam logic [2:0] OP_BLOCK   = 3'h6;
  localparam logic [2:0] OP_QID     = 3'h7;
  // bus cycle timing at 125 MHz
  localparam int CLK_NS       = 8;
  localparam int RD_PULSE_NS  = 80;
  localparam int WR_PULSE_NS  = 64;
  localparam int RECOVER_NS   = 24;
  localparam int RD_PULSE_CYC = (RD_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC  = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [testbench/flash_model.sv]
// behavioural flash device seen by the host controller
`timescale 1ns/1ps
module flash_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC4, // arbitrary value
  parameter logic [7:0] GEOM     = 8'h16
) (
  input  wire logic [21:0] fl_addr,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_dq_oe,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  output logic      [15:0] fl_dq_i
);
  logic [7:0]  mode_q   = CMD_ARRAY;
  logic        paused_q = 1'b0;
  int          busy_q   = 0;
  logic [15:0] out_q    = 16'h0000;
  logic [7:0]  qb;
  // commands at any address
  // data enable still high at the strobe edge; reset edges are ignored
  always @(posedge fl_we_n) if (fl_dq_oe === 1'b1) begin
    case (fl_dq_o[7:0])
      CMD_SUSPEND: begin
        mode_q = CMD_STATUS;
        paused_q = 1'b1;
        busy_q = 2;
      end
      CMD_RESUME: begin
        mode_q = CMD_ARRAY;
        paused_q = 1'b0;
      end
      default: mode_q = fl_dq_o[7:0];
    endcase
  end
  always @(negedge fl_oe_n) begin
    #1;
    if (fl_addr[14:0] == 15'h0002) qb = {5'b0, fl_addr[17:15]};
    else begin
      case (fl_addr[7:0])
        8'h00: qb = MFR_CODE;
        8'h01: qb = DEV_CODE;
        8'h10: qb = 8'h51;
        8'h11: qb = 8'h52;
        8'h12: qb = 8'h59;
        8'h13: qb = 8'h03;
        8'h15: qb = 8'h35;
        8'h27: qb = GEOM;
        default: qb = 8'h00;
      endcase
    end
    if (mode_q == CMD_STATUS) out_q = {8'h00, busy_q == 0, 4'h0, paused_q, 2'b00};
    else if (mode_q == CMD_QUERY) out_q = {8'h00, qb};
    else out_q = fl_addr[15:0] ^ 16'h5A5A;
    if (busy_q > 0) busy_q = busy_q - 1;
  end
  // released bus shows inverse, not a stale value
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? out_q : ~out_q;
endmodule

// [testbench/tb.sv]
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
  import flash_host_pkg::*;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, st, dat, rv, a, seed;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  int          num_errors, cmp_count;
  flash_host flash_host_inst (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .fl_addr, .fl_dq_o, .fl_dq_oe,
    .fl_dq_i, .fl_ce_n, .fl_oe_n, .fl_we_n);
  flash_model flash_model_inst (.fl_addr, .fl_dq_o, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_dq_i);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] field_exp(input int i);
    logic [15:0] t [4] = '{16'h0003, 16'h0035, 16'h0000, 16'h0016};
    return t[i];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_awaddr <= ad;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_awready) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    chk(s_bresp, 32'h0);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    s_araddr <= ad;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    chk(s_rresp, 32'h0);
    s_rready <= 1'b0;
  endtask
  task automatic op(input logic [2:0] o, input logic [31:0] ad, input logic [31:0] ctl);
    int n;
    n = 0;
    wr(OFF_ADDR, ad);
    wr(OFF_CTRL, ctl | {29'b0, o});
    do begin
      rd(OFF_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 500);
    if (st[0] !== 1'b0) begin
      num_errors++;
      results();
    end
    rd(OFF_DATA, dat);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    results();
  end
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, aresetn} = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    seed = 39;
    num_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_CTRL, rv);
    chk(rv, CTRL_RST);
    rd(OFF_PBLK, rv);
    chk(rv, PBLK_RST);
    rd(8'h3C, rv);
    chk(rv, 32'h0);
    $display("test registers done");
    wr(OFF_PBLK, 32'h1);
    op(OP_SUSPEND, xs() & 32'h3FFFFF, 0);
    chk(st[2:1], 2'b11);
    a = xs() & 32'h7FFF;
    op(OP_ARRAY, a, 0);
    chk(dat[15:0], a[15:0] ^ 16'h5A5A);
    op(OP_ARRAY, a | 32'h8000, 0);
    chk(st[6], 1'b1);
    op(OP_RESUME, xs() & 32'h3FFFFF, 0);
    chk(st[2], 1'b0);
    $display("test suspend done");
    op(OP_QID, 0, 0);
    chk(st[5:4], 2'b01);
    op(OP_QREAD, 32'h10, 32'h20);
    chk(dat[23:0], 24'h595251);
    for (int i = 0; i < 4; i++) begin
      op(OP_QFIELD, 0, i << 8);
      chk(dat[15:0], field_exp(i) & (i == 3 ? 16'h00FF : 16'hFFFF));
    end
    op(OP_QREAD, 32'h0, 32'h10);
    chk(dat[15:0], 16'hC45A);
    op(OP_QREAD, 32'h4 + (xs() % 12), 0);
    chk(st[7], 1'b1);
    $display("test query done");
    // block 4 makes the model report a reserved bit
    for (int b = 0; b < 5; b++) begin
      op(OP_BLOCK, b, 0);
      rd(OFF_LOCK, rv);
      chk(rv[7:0], {5'b0, b[2:0]});
      chk({st[7], st[3]}, {b == 4, 1'b1});
    end
    op(OP_ARRAY, a, 0);
    chk(st[3], 1'b0);
    $display("test block status done");
    results();
  end
endmodule
